// ==== src/qup_device.sv ====
`timescale 1ns/1ps
`include "qup_params.svh"
// Summary of operation
// - pin high dual-strobe, low read/write line
// - read strobe fall drives addressed byte
// - write strobe rise latches data byte
// - four selects, one channel each
// - direction line: high read, low write
// - channel A select gates every access
// - B, C selects become channel address
// - D select and read strobe ignored
// - modem bit 3 enables each channel's own irq
// - shared irq open drain, active low
// - three address bits pick register
// - drive data only during reads
// - force input keeps irqs always driven in dual-strobe style
// - unused irqs held low
module qup_device
    import qup_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // host bus
    qup_bus_if.dev bus,
    // uart core side
    input wire logic [3:0] chan_irq_i,
    output logic [3:0] modem_control_reg_o,
    output logic [3:0] wr_pulse_o,
    output logic [2:0] wr_addr_o,
    output logic [7:0] wr_data_o
);
    // three-stage synchronisers for all pin inputs except the register address
    localparam int NS = 8;
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] s1_reg, s2_reg, s3_reg, s1_next, s2_next, s3_next;
    logic [NS-1:0] pin_reg, pin_next;
    logic [7:0] d1_reg, d2_reg, d3_reg, dat_reg, d1_next, d2_next, d3_next, dat_next;
    assign pin_raw = {bus.bus_style, bus.read_strobe_n, bus.write_strobe_n, bus.chan_a_select_n,
                      bus.chan_b_select_n, bus.chan_c_select_n, bus.chan_d_select_n,
                      bus.irq_force_enable};
    always_comb
    begin
        s1_next = pin_raw;
        s2_next = s1_reg;
        s3_next = s2_reg;
        d1_next = bus.data_bus;
        d2_next = d1_reg;
        d3_next = d2_reg;
        // agreed byte is kept, so it still holds when the release is seen
        dat_next = (d2_reg == d3_reg) ? d2_reg : dat_reg;
        pin_next = pin_reg;
        for (int i = 0; i < NS; i++)
        begin
            if (s2_reg[i] == s3_reg[i])
                pin_next[i] = s2_reg[i];
        end
    end
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
            pin_reg <= '1;
            d1_reg <= 8'h00;
            d2_reg <= 8'h00;
            d3_reg <= 8'h00;
            dat_reg <= 8'h00;
        end
        else
        begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            pin_reg <= pin_next;
            d1_reg <= d1_next;
            d2_reg <= d2_next;
            d3_reg <= d3_next;
            dat_reg <= dat_next;
        end
    end
    logic style, rd_n, wr_n, csa_n, csb_n, csc_n, csd_n, force_en;
    assign {style, rd_n, wr_n, csa_n, csb_n, csc_n, csd_n, force_en} = pin_reg;
    // decode access request and target channel
    logic req_rd, req_wr, sel_any;
    qup_chan_t chan;
    always_comb
    begin
        req_rd = 1'b0;
        req_wr = 1'b0;
        sel_any = 1'b0;
        chan = 2'h0;
        if (style == `QUP_STYLE_DUAL)
        begin
            sel_any = ~(csa_n & csb_n & csc_n & csd_n);
            if (!csa_n)
                chan = 2'h0;
            else if (!csb_n)
                chan = 2'h1;
            else if (!csc_n)
                chan = 2'h2;
            else
                chan = 2'h3;
            req_rd = sel_any & ~rd_n;
            req_wr = sel_any & ~wr_n;
        end
        else
        begin
            // channel D select and read strobe are never looked at
            sel_any = ~csa_n;
            chan = {csc_n, csb_n};
            req_rd = sel_any & (wr_n == `QUP_DIR_READ);
            req_wr = sel_any & (wr_n == `QUP_DIR_WRITE);
        end
    end
    // register file: four channels of eight bytes
    qup_byte_t regs_reg [`QUP_NUM_CHAN][`QUP_NUM_REG];
    qup_byte_t regs_next [`QUP_NUM_CHAN][`QUP_NUM_REG];
    qup_cycle_e state_reg, state_next;
    qup_chan_t chan_reg, chan_next;
    qup_reg_addr_t addr_reg, addr_next;
    qup_byte_t rd_data_reg, rd_data_next;
    logic [3:0] wr_pulse_reg, wr_pulse_next;
    always_comb
    begin
        regs_next = regs_reg;
        state_next = state_reg;
        chan_next = chan_reg;
        addr_next = addr_reg;
        rd_data_next = rd_data_reg;
        wr_pulse_next = 4'h0;
        case (state_reg)
            QUP_IDLE:
            begin
                if (req_rd)
                begin
                    state_next = QUP_READ;
                    chan_next = chan;
                    addr_next = bus.reg_addr;
                    rd_data_next = regs_reg[chan][bus.reg_addr];
                end
                else if (req_wr)
                begin
                    state_next = QUP_WRITE;
                    chan_next = chan;
                    addr_next = bus.reg_addr;
                end
            end
            QUP_READ:
            begin
                if (!req_rd)
                    state_next = QUP_IDLE;
            end
            QUP_WRITE:
            begin
                if (!req_wr)
                begin
                    // byte is taken as the strobe or select releases
                    regs_next[chan_reg][addr_reg] = dat_reg;
                    wr_pulse_next[chan_reg] = 1'b1;
                    state_next = QUP_IDLE;
                end
            end
            default:
                state_next = QUP_IDLE;
        endcase
    end
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            for (int c = 0; c < `QUP_NUM_CHAN; c++)
                for (int r = 0; r < `QUP_NUM_REG; r++)
                    regs_reg[c][r] <= `QUP_REG_RST;
            state_reg <= QUP_IDLE;
            chan_reg <= 2'h0;
            addr_reg <= 3'h0;
            rd_data_reg <= 8'h00;
            wr_pulse_reg <= 4'h0;
        end
        else
        begin
            regs_reg <= regs_next;
            state_reg <= state_next;
            chan_reg <= chan_next;
            addr_reg <= addr_next;
            rd_data_reg <= rd_data_next;
            wr_pulse_reg <= wr_pulse_next;
        end
    end
    // data bus driven only while a read is open
    assign bus.data_dev = rd_data_reg;
    assign bus.data_dev_oe = (state_reg == QUP_READ);
    // modem control bit 3 of each channel, register index 4
    genvar g;
    generate
        for (g = 0; g < `QUP_NUM_CHAN; g++)
        begin : g_mcr
            assign modem_control_reg_o[g] = regs_reg[g][4][`QUP_MCR_IRQ_EN_BIT];
        end
    endgenerate
    assign wr_pulse_o = wr_pulse_reg;
    assign wr_addr_o = addr_reg;
    assign wr_data_o = regs_reg[chan_reg][addr_reg];
    // interrupt pin levels and drivers
    logic [3:0] irq_lvl_reg, irq_lvl_next, irq_oe_reg, irq_oe_next;
    always_comb
    begin
        irq_lvl_next = 4'h0;
        irq_oe_next = 4'h0;
        if (style == `QUP_STYLE_DUAL)
        begin
            irq_lvl_next = chan_irq_i;
            irq_oe_next = force_en ? 4'hf : modem_control_reg_o;
        end
        else
        begin
            irq_lvl_next = 4'h0;
            irq_oe_next = {3'h7, |chan_irq_i};
        end
    end
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            irq_lvl_reg <= 4'h0;
            irq_oe_reg <= 4'h0;
        end
        else
        begin
            irq_lvl_reg <= irq_lvl_next;
            irq_oe_reg <= irq_oe_next;
        end
    end
    assign bus.irq_level = irq_lvl_reg;
    assign bus.irq_oe = irq_oe_reg;
endmodule : qup_device

// ==== pkg/qup_params.svh ====
`ifndef QUP_PARAMS_SVH
`define QUP_PARAMS_SVH
// bus style pin levels
`define QUP_STYLE_DUAL 1'b1
`define QUP_STYLE_RW 1'b0
// direction line levels in read/write-line style
`define QUP_DIR_READ 1'b1
`define QUP_DIR_WRITE 1'b0
// modem control bit that enables the interrupt drivers
`define QUP_MCR_IRQ_EN_BIT 3
// register file shape
`define QUP_NUM_CHAN 4
`define QUP_NUM_REG 8
`define QUP_REG_RST 8'h00
`endif

// ==== pkg/qup_pkg.sv ====
package qup_pkg;
    typedef logic [7:0] qup_byte_t;
    typedef logic [2:0] qup_reg_addr_t;
    typedef logic [1:0] qup_chan_t;
    typedef enum logic [1:0] {QUP_IDLE, QUP_READ, QUP_WRITE} qup_cycle_e;
endpackage : qup_pkg

// ==== pkg/qup_bus_if.sv ====
`timescale 1ns/1ps
interface qup_bus_if;
    logic bus_style;
    logic read_strobe_n;
    logic write_strobe_n;
    logic chan_a_select_n;
    logic chan_b_select_n;
    logic chan_c_select_n;
    logic chan_d_select_n;
    logic [2:0] reg_addr;
    logic [7:0] data_host;
    logic data_host_oe;
    logic [7:0] data_dev;
    logic data_dev_oe;
    logic irq_force_enable;
    logic [3:0] irq_level;
    logic [3:0] irq_oe;
    // resolved data bus seen by both ends
    logic [7:0] data_bus;
    assign data_bus = data_dev_oe ? data_dev : (data_host_oe ? data_host : 8'hff);
    modport dev (
        input bus_style, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
        input chan_c_select_n, chan_d_select_n, reg_addr, data_bus, irq_force_enable,
        output data_dev, data_dev_oe, irq_level, irq_oe
    );
    modport host (
        output bus_style, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
        output chan_c_select_n, chan_d_select_n, reg_addr, data_host, data_host_oe, irq_force_enable,
        input data_bus, irq_level, irq_oe
    );
endinterface : qup_bus_if

// ==== src/qup_host.sv ====
`timescale 1ns/1ps
`include "qup_params.svh"
module qup_host
    import qup_pkg::*;
#(
    parameter int STROBE_CYCLES = 6
)
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // user request
    input wire logic style_i,
    input wire logic force_irq_i,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [1:0] req_chan_i,
    input wire logic [2:0] req_addr_i,
    input wire logic [7:0] req_data_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rd_data_o,
    // bus
    qup_bus_if.host bus
);
    typedef enum logic [1:0] {QH_IDLE, QH_SETUP, QH_STROBE, QH_HOLD} qup_host_e;
    qup_host_e st_reg, st_next;
    logic [7:0] cnt_reg, cnt_next;
    logic wr_reg, wr_next;
    logic [1:0] ch_reg, ch_next;
    logic [2:0] ad_reg, ad_next;
    logic [7:0] wd_reg, wd_next, rd_reg, rd_next;
    logic done_reg, done_next;
    // access sequencer: setup, strobe, hold
    always_comb
    begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        wr_next = wr_reg;
        ch_next = ch_reg;
        ad_next = ad_reg;
        wd_next = wd_reg;
        rd_next = rd_reg;
        done_next = 1'b0;
        case (st_reg)
            QH_IDLE:
            begin
                if (req_i)
                begin
                    wr_next = req_write_i;
                    ch_next = req_chan_i;
                    ad_next = req_addr_i;
                    wd_next = req_data_i;
                    st_next = QH_SETUP;
                end
            end
            QH_SETUP:
            begin
                cnt_next = 8'(STROBE_CYCLES);
                st_next = QH_STROBE;
            end
            QH_STROBE:
            begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == 8'h01)
                begin
                    rd_next = wr_reg ? rd_reg : bus.data_bus;
                    st_next = QH_HOLD;
                end
            end
            QH_HOLD:
            begin
                done_next = 1'b1;
                st_next = QH_IDLE;
            end
            default:
                st_next = QH_IDLE;
        endcase
    end
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            st_reg <= QH_IDLE;
            cnt_reg <= 8'h00;
            wr_reg <= 1'b0;
            ch_reg <= 2'h0;
            ad_reg <= 3'h0;
            wd_reg <= 8'h00;
            rd_reg <= 8'h00;
            done_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            wr_reg <= wr_next;
            ch_reg <= ch_next;
            ad_reg <= ad_next;
            wd_reg <= wd_next;
            rd_reg <= rd_next;
            done_reg <= done_next;
        end
    end
    logic act, strb;
    assign act = (st_reg != QH_IDLE);
    assign strb = (st_reg == QH_STROBE);
    // pin drive per bus style
    always_comb
    begin
        bus.bus_style = style_i;
        bus.irq_force_enable = style_i & force_irq_i;
        bus.reg_addr = ad_reg;
        bus.data_host = wd_reg;
        bus.data_host_oe = act & wr_reg;
        bus.chan_d_select_n = 1'b1;
        if (style_i == `QUP_STYLE_DUAL)
        begin
            bus.read_strobe_n = ~(strb & ~wr_reg);
            bus.write_strobe_n = ~(strb & wr_reg);
            bus.chan_a_select_n = ~(act && ch_reg == 2'h0);
            bus.chan_b_select_n = ~(act && ch_reg == 2'h1);
            bus.chan_c_select_n = ~(act && ch_reg == 2'h2);
            bus.chan_d_select_n = ~(act && ch_reg == 2'h3);
        end
        else
        begin
            bus.read_strobe_n = 1'b1;
            bus.write_strobe_n = wr_reg ? `QUP_DIR_WRITE : `QUP_DIR_READ;
            bus.chan_a_select_n = ~strb;
            bus.chan_b_select_n = ch_reg[0];
            bus.chan_c_select_n = ch_reg[1];
        end
    end
    assign busy_o = act;
    assign done_o = done_reg;
    assign rd_data_o = rd_reg;
endmodule : qup_host

// ==== bench/qup_bus_assertions.sv ====
`timescale 1ns/1ps
module qup_bus_assertions (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // bus pins
    input wire logic bus_style,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chan_a_select_n,
    input wire logic chan_b_select_n,
    input wire logic chan_c_select_n,
    input wire logic chan_d_select_n,
    input wire logic irq_force_enable,
    input wire logic data_dev_oe,
    input wire logic [3:0] irq_level,
    input wire logic [3:0] irq_oe
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    // requests as each style decodes them
    logic any_sel;
    logic rd_req;
    logic wr_req;
    assign any_sel = bus_style ? !(chan_a_select_n & chan_b_select_n & chan_c_select_n & chan_d_select_n)
        : !chan_a_select_n;
    assign rd_req = any_sel && (bus_style ? !read_strobe_n : write_strobe_n);
    assign wr_req = any_sel && !write_strobe_n;
    // data drive follows reads only
    AST_RD_CAUSE: assert property ($rose(data_dev_oe) |-> $past(rd_req, 2))
        else $error("data driven without a read");
    AST_RD_ANSWER: assert property (rd_req [*6] |-> data_dev_oe)
        else $error("read not answered during strobe");
    AST_WR_QUIET: assert property (wr_req [*5] |-> !data_dev_oe)
        else $error("data driven during write");
    AST_DUAL_NOSEL: assert property ((bus_style && !any_sel) [*8] |-> !data_dev_oe)
        else $error("data driven with no select");
    AST_RW_NOCS: assert property ((!bus_style && chan_a_select_n) [*8] |-> !data_dev_oe)
        else $error("data driven without chip select");
    // interrupt pin modes
    AST_FORCE: assert property ((bus_style && irq_force_enable) [*8] |-> irq_oe == 4'hf)
        else $error("forced irq outputs not driven");
    AST_RW_OD: assert property ((!bus_style) [*8] |-> !(irq_oe[0] && irq_level[0]))
        else $error("shared irq drives high");
    AST_RW_UNUSED: assert property ((!bus_style) [*8] |-> irq_oe[3:1] == 3'h7 && irq_level[3:1] == 3'h0)
        else $error("unused irq outputs not low");
    // main scenarios reached
    cover property (rd_req && data_dev_oe);
    cover property (wr_req [*5]);
    cover property (!bus_style && irq_oe[0]);
endmodule : qup_bus_assertions

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import qup_pkg::*;
    // clock, reset and user side
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic style = 1'b1;
    logic force_irq = 1'b0;
    logic req = 1'b0;
    logic req_wr = 1'b0;
    logic [1:0] req_chan = 2'h0;
    logic [2:0] req_addr = 3'h0;
    qup_byte_t req_data = 8'h00;
    logic [3:0] chan_irq = 4'h0;
    logic busy;
    logic done;
    qup_byte_t rd_data;
    logic [3:0] modem_control_reg;
    logic [3:0] wr_pulse;
    logic [2:0] wr_addr;
    qup_byte_t wr_data;
    int n_fail = 0;
    int samples_checked = 0;
    int mem [4][8];
    qup_bus_if bus_if ();
    // free running clock
    always #5 mclk_i = ~mclk_i;
    // both ends joined by the interface
    qup_device qup_device_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus(bus_if), .chan_irq_i(chan_irq),
        .modem_control_reg_o(modem_control_reg), .wr_pulse_o(wr_pulse), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
    qup_host qup_host_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .style_i(style), .force_irq_i(force_irq),
        .req_i(req), .req_write_i(req_wr), .req_chan_i(req_chan), .req_addr_i(req_addr), .req_data_i(req_data),
        .busy_o(busy), .done_o(done), .rd_data_o(rd_data), .bus(bus_if));
    qup_bus_assertions qup_bus_assertions_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .bus_style(bus_if.bus_style), .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
        .chan_a_select_n(bus_if.chan_a_select_n), .chan_b_select_n(bus_if.chan_b_select_n),
        .chan_c_select_n(bus_if.chan_c_select_n), .chan_d_select_n(bus_if.chan_d_select_n),
        .irq_force_enable(bus_if.irq_force_enable), .data_dev_oe(bus_if.data_dev_oe),
        .irq_level(bus_if.irq_level), .irq_oe(bus_if.irq_oe));
    // verdict and end of run
    task automatic test_done();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    // one comparison
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    // reset with a new bus style, model cleared
    task automatic do_reset(input logic st);
        sys_rst_i = 1'b1;
        style = st;
        repeat (12) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        foreach (mem[c, r]) mem[c][r] = 0;
        repeat (6) @(negedge mclk_i);
    endtask : do_reset
    // one host access, read data compared with the model
    task automatic access(input logic wr, input int c, input int r, input int d);
        int k;
        req = 1'b1;
        req_wr = wr;
        req_chan = 2'(c);
        req_addr = 3'(r);
        req_data = 8'(d);
        @(negedge mclk_i);
        req = 1'b0;
        for (k = 0; k < 40 && done !== 1'b1; k++) @(negedge mclk_i);
        if (k == 40)
        begin
            n_fail++;
            test_done();
        end
        if (wr)
        begin
            mem[c][r] = d & 8'hff;
            // commit shows a few cycles after the strobe releases
            for (k = 0; k < 20 && wr_pulse === 4'h0; k++) @(negedge mclk_i);
            check("write pulse", 8'(1 << c), 8'(wr_pulse));
            check("write address", 8'(r), 8'(wr_addr));
            check("write data", 8'(d), wr_data);
        end
        else
            check("read data", 8'(mem[c][r]), rd_data);
        repeat (6) @(negedge mclk_i);
    endtask : access
    // expected modem control bits of all channels
    function automatic logic [3:0] mcr_model();
        logic [3:0] e;
        for (int c = 0; c < 4; c++) e[c] = mem[c][4][3];
        return e;
    endfunction : mcr_model
    // main sequence: dual-strobe pass, then read/write-line pass
    initial
    begin
        void'($urandom(75031));
        for (int s = 1; s >= 0; s--)
        begin
            do_reset(s[0]);
            for (int c = 0; c < 4; c++)
                for (int r = 0; r < 8; r++)
                begin
                    access(1'b1, c, r, $urandom);
                    check("modem bits", 8'(mcr_model()), 8'(modem_control_reg));
                end
            for (int c = 0; c < 4; c++)
                for (int r = 0; r < 8; r++) access(1'b0, c, r, 0);
            chan_irq = 4'($urandom) | 4'h1;
            repeat (8) @(negedge mclk_i);
            if (s == 1)
            begin
                check("irq enables", 8'(mcr_model()), 8'(bus_if.irq_oe));
                check("irq levels", 8'(chan_irq), 8'(bus_if.irq_level));
                force_irq = 1'b1;
                repeat (8) @(negedge mclk_i);
                check("forced irq enables", 8'h0f, 8'(bus_if.irq_oe));
                force_irq = 1'b0;
            end
            else
            begin
                check("shared irq", 8'h1e, {3'h0, bus_if.irq_oe[3:1], bus_if.irq_oe[0], bus_if.irq_level[0]});
                chan_irq = 4'h0;
                repeat (8) @(negedge mclk_i);
                check("idle irq", 8'h00, 8'(bus_if.irq_oe[0]));
            end
            $display("test style %0d done", s);
        end
        test_done();
    end
endmodule : testbench
